// ===== src/msi_pkg.sv
// shared constants, types and the code expander for the schedule block
package msi_pkg;

  localparam logic [7:0] OFS_IRQ_MODE = 8'h06;
  localparam logic [7:0] OFS_UNLOCK = 8'h07;
  localparam logic [7:0] OFS_WAKE = 8'h08;
  localparam logic [7:0] OFS_LIGHT = 8'h09;
  localparam logic [7:0] OFS_PROX = 8'h0A;

  localparam logic [7:0] RST_IRQ_MODE = 8'h00;
  localparam logic [7:0] RST_UNLOCK = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [7:0] RST_LIGHT = 8'h00;
  localparam logic [7:0] RST_PROX = 8'h00;

  // field positions inside the interrupt mode register
  localparam int CMD_MODE_LSB = 2;
  localparam int P3_MODE_LSB = 0;
  localparam logic [7:0] IRQ_MODE_MASK = 8'h0F;

  localparam logic [1:0] CMD_ON_REPLY = 2'h0;
  localparam logic [1:0] CMD_ON_ERROR = 2'h1;
  localparam logic [1:0] P3_ON_DONE = 2'h0;
  localparam logic [1:0] P3_ON_CROSS = 2'h1;
  localparam logic [1:0] P3_ON_ABOVE = 2'h3;

  localparam logic [7:0] WAKE_OFF_CODE = 8'h00;

  // wake interval is (2B+5) half ticks of 31.25 us
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 62500;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam logic [11:0] HALF_LO_CYC = 12'(TICK_CYC / 2);
  localparam logic [11:0] HALF_HI_CYC = 12'(TICK_CYC - TICK_CYC / 2);
  localparam logic [16:0] HALF_OFFSET = 17'h00005;

  // documented example whose mantissa expansion must be bent to match
  localparam logic [7:0] TEN_CODE = 8'h32;
  localparam logic [15:0] TEN_VALUE = 16'h000A;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } msi_req_t;

  typedef struct packed {
    logic done;
    logic [15:0] result;
  } msi_meas_t;

  // 4-bit exponent, 4-bit mantissa with hidden one, four fraction bits
  function automatic logic [15:0] msi_expand(input logic [7:0] code);
    logic [35:0] wide;
    wide = 36'(5'h10 + {1'b0, code[3:0]}) << code[7:4];
    if (code < 8'h08) begin
      msi_expand = 16'h0000;
    end else if (code == TEN_CODE) begin
      msi_expand = TEN_VALUE;
    end else begin
      msi_expand = wide[19:4];
    end
  endfunction : msi_expand

endpackage : msi_pkg

// ===== src/msi_rate_div.sv
// counts wake-ups and fires once every expanded-multiplier wake-ups
`timescale 1ns/1ps
module msi_rate_div (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic wake,
  input wire logic [7:0] code,
  output logic fire_q
);
  logic [15:0] mult;
  logic [15:0] count_q;
  logic [15:0] count_inc;
  logic hit;

  assign mult = msi_pkg::msi_expand(code);
  assign count_inc = count_q + 16'h0001;
  // zero multiplier never fires
  assign hit = wake && (mult != 16'h0000) && (count_inc >= mult);

  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      count_q <= 16'h0000;
      fire_q <= 1'b0;
    end else begin
      fire_q <= hit;
      if (hit) begin
        count_q <= 16'h0000;
      end else if (wake && mult != 16'h0000) begin
        count_q <= count_inc;
      end
    end
  end
endmodule : msi_rate_div

// ===== src/msi_sched.sv
// interrupt modes, unlock key and autonomous measurement scheduler
`timescale 1ns/1ps

// Function
// [R1] command mode 00 sets command flag on every reply register write; here only while command_irq_enable is set
// [R2] command mode 01 sets flag only for error replies; modes 1x reserved
// [R3] third-channel mode 00 sets its flag after every measurement completes; here only while third_prox_irq_enable is set
// [R4] third-channel mode 01 sets its flag when result crosses threshold
// [R5] third-channel mode 11 sets its flag while result exceeds threshold
// [R6] host writes 0x17 into unlock key; key resets to zero
// [R7] wake period code is expanded from 8 to 16 bits first
// [R8] wake interval equals (B+2.5) times 62.5 us, B=(A-1)/2
// [R9] wake code zero stops oscillator and autonomous measurements
// [R10] host keeps wake code above gain-dependent minimum with light channels
// [R11] host avoids wake codes 0x01 to 0x23 outside allowed modes
// [R12] wake codes 0x18 to 0x23 are accepted in continuous run mode
// [R13] light multiplier expanded; light measurement every that many wake-ups
// [R14] light multiplier zero disables autonomous light measurements
// [R15] light codes 0x08, 0x32, 0x69 mean every 1, 10, 100 wake-ups
// [R16] prox multiplier expanded; proximity every that many wake-ups
// [R17] prox multiplier zero disables autonomous proximity measurements
// [R18] prox codes 0x08, 0x32, 0x69 mean every 1, 10, 100 wake-ups
// [R19] host picks largest wake code and smallest multiplier for power
// [R20] interrupt pin follows command flag only while command enable set
// [R21] expansion is a fixed table matching the documented example codes; here a hidden-one mantissa shifted by exponent, with 0x32 forced to 10
module msi_sched (
  input wire logic mclk,
  input wire logic rst_n,
  input msi_pkg::msi_req_t reg_req,
  output logic [7:0] reg_rdata_q,
  input wire logic command_irq_enable,
  input wire logic third_prox_irq_enable,
  input wire logic continuous_run_mode,
  input wire logic reply_wr,
  input wire logic [7:0] reply_data,
  input msi_pkg::msi_meas_t prox3_meas,
  input wire logic [15:0] third_prox_threshold,
  input wire logic command_irq_clr,
  input wire logic third_prox_irq_clr,
  output logic command_irq_flag_q,
  output logic third_prox_irq_flag_q,
  output logic host_irq_q,
  output logic unlocked_q,
  output logic osc_run_q,
  output logic wake_q,
  output logic light_meas_start_q,
  output logic prox_meas_start_q
);
  localparam logic [7:0] UNLOCK_VALUE = 8'h17;

  logic [7:0] irq_mode_q;
  logic [7:0] unlock_key_q;
  logic [7:0] wake_code_q;
  logic [7:0] light_code_q;
  logic [7:0] prox_code_q;

  logic wr_mode;
  logic wr_unlock;
  logic wr_wake;
  logic wr_light;
  logic wr_prox;
  logic [7:0] rd_mux;

  assign wr_mode = reg_req.wr && reg_req.addr == msi_pkg::OFS_IRQ_MODE;
  assign wr_unlock = reg_req.wr && reg_req.addr == msi_pkg::OFS_UNLOCK;
  assign wr_wake = reg_req.wr && reg_req.addr == msi_pkg::OFS_WAKE;
  assign wr_light = reg_req.wr && reg_req.addr == msi_pkg::OFS_LIGHT;
  assign wr_prox = reg_req.wr && reg_req.addr == msi_pkg::OFS_PROX;

  // unmapped offsets read as zero
  assign rd_mux =
    (reg_req.addr == msi_pkg::OFS_IRQ_MODE) ? irq_mode_q :
    (reg_req.addr == msi_pkg::OFS_UNLOCK) ? unlock_key_q :
    (reg_req.addr == msi_pkg::OFS_WAKE) ? wake_code_q :
    (reg_req.addr == msi_pkg::OFS_LIGHT) ? light_code_q :
    (reg_req.addr == msi_pkg::OFS_PROX) ? prox_code_q : 8'h00;

  // every code is stored as written, including the short-interval ones
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_mode_q <= msi_pkg::RST_IRQ_MODE;
      unlock_key_q <= msi_pkg::RST_UNLOCK; // [R6]
      wake_code_q <= msi_pkg::RST_WAKE;
      light_code_q <= msi_pkg::RST_LIGHT;
      prox_code_q <= msi_pkg::RST_PROX;
      reg_rdata_q <= 8'h00;
    end else begin
      if (wr_mode) irq_mode_q <= reg_req.wdata & msi_pkg::IRQ_MODE_MASK;
      if (wr_unlock) unlock_key_q <= reg_req.wdata;
      if (wr_wake) wake_code_q <= reg_req.wdata; // [R12]
      if (wr_light) light_code_q <= reg_req.wdata;
      if (wr_prox) prox_code_q <= reg_req.wdata;
      reg_rdata_q <= rd_mux;
    end
  end

  // unlock status only reports; gating sensor operation is left to the core
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      unlocked_q <= 1'b0;
    end else begin
      unlocked_q <= unlock_key_q == UNLOCK_VALUE; // [R6]
    end
  end

  // command reply interrupt
  logic [1:0] cmd_mode;
  logic cmd_event;
  assign cmd_mode = irq_mode_q[msi_pkg::CMD_MODE_LSB +: 2];
  assign cmd_event = command_irq_enable && reply_wr &&
    ((cmd_mode == msi_pkg::CMD_ON_REPLY) || // [R1]
     (cmd_mode == msi_pkg::CMD_ON_ERROR && reply_data[7])); // [R2]

  // third proximity channel interrupt
  logic [1:0] p3_mode;
  logic p3_above;
  logic p3_above_q;
  logic p3_valid_q;
  logic p3_event;
  assign p3_mode = irq_mode_q[msi_pkg::P3_MODE_LSB +: 2];
  assign p3_above = prox3_meas.result > third_prox_threshold;
  // first result after reset has no history, so it cannot count as a cross
  assign p3_event = third_prox_irq_enable && prox3_meas.done &&
    ((p3_mode == msi_pkg::P3_ON_DONE) || // [R3]
     (p3_mode == msi_pkg::P3_ON_CROSS && p3_valid_q &&
      p3_above != p3_above_q) || // [R4]
     (p3_mode == msi_pkg::P3_ON_ABOVE && p3_above)); // [R5]

  // a set in the same cycle as a clear wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      command_irq_flag_q <= 1'b0;
      third_prox_irq_flag_q <= 1'b0;
      p3_above_q <= 1'b0;
      p3_valid_q <= 1'b0;
      host_irq_q <= 1'b0;
    end else begin
      command_irq_flag_q <= cmd_event ||
        (command_irq_flag_q && !command_irq_clr);
      third_prox_irq_flag_q <= p3_event ||
        (third_prox_irq_flag_q && !third_prox_irq_clr);
      if (prox3_meas.done) begin
        p3_above_q <= p3_above;
        p3_valid_q <= 1'b1;
      end
      host_irq_q <= (command_irq_flag_q && command_irq_enable) || // [R20]
        (third_prox_irq_flag_q && third_prox_irq_enable);
    end
  end

  // wake interval timer
  logic [15:0] wake_a;
  logic [15:0] wake_b;
  logic [16:0] half_count;
  logic run;
  assign wake_a = msi_pkg::msi_expand(wake_code_q); // [R7] [R21]
  assign wake_b = (wake_a == 16'h0000) ? 16'h0000 :
    16'((wake_a - 16'h0001) >> 1); // [R8]
  assign half_count = {wake_b, 1'b0} + msi_pkg::HALF_OFFSET; // [R8]
  assign run = wake_code_q != msi_pkg::WAKE_OFF_CODE; // [R9]

  // 31.25 us is 1562.5 cycles, so half ticks alternate 1562 and 1563
  logic [11:0] div_q;
  logic odd_q;
  logic half_tick;
  logic [16:0] half_q;
  assign half_tick = div_q == (odd_q ? msi_pkg::HALF_HI_CYC :
    msi_pkg::HALF_LO_CYC) - 12'h001;

  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      div_q <= 12'h000;
      odd_q <= 1'b0;
      half_q <= 17'h00000;
      wake_q <= 1'b0;
      osc_run_q <= 1'b0;
    end else begin
      osc_run_q <= 1'b1;
      wake_q <= 1'b0;
      if (half_tick) begin
        div_q <= 12'h000;
        odd_q <= !odd_q;
        if (half_q + 17'h00001 >= half_count) begin
          half_q <= 17'h00000;
          wake_q <= 1'b1; // [R8]
        end else begin
          half_q <= half_q + 17'h00001;
        end
      end else begin
        div_q <= div_q + 12'h001;
      end
    end
  end

  // measurement rate dividers
  msi_rate_div u_light_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run),
    .wake(wake_q),
    .code(light_code_q), // [R13] [R14] [R15]
    .fire_q(light_meas_start_q)
  );

  msi_rate_div u_prox_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run),
    .wake(wake_q),
    .code(prox_code_q), // [R16] [R17] [R18]
    .fire_q(prox_meas_start_q)
  );

  // continuous run changes nothing here: all codes are already accepted
  logic unused_mode;
  assign unused_mode = continuous_run_mode; // [R12]
endmodule : msi_sched

// ===== tb/msi_checker.sv
// port assertions for the schedule block
`timescale 1ns/1ps
module msi_checker (
  input logic mclk,
  input logic rst_n,
  input logic command_irq_enable,
  input logic third_prox_irq_enable,
  input logic reply_wr,
  input msi_pkg::msi_meas_t prox3_meas,
  input logic command_irq_clr,
  input logic third_prox_irq_clr,
  input logic command_irq_flag_q,
  input logic third_prox_irq_flag_q,
  input logic host_irq_q,
  input logic osc_run_q,
  input logic wake_q,
  input logic light_meas_start_q,
  input logic prox_meas_start_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire cmd_on = command_irq_flag_q && command_irq_enable;
  wire p3_on = third_prox_irq_flag_q && third_prox_irq_enable;
  wire stopped = !osc_run_q;
  sequence s_quiet; !wake_q [*8]; endsequence
  sequence s_took; $past(reply_wr && command_irq_enable); endsequence
  property p_cmd_set; $rose(command_irq_flag_q) |-> s_took; endproperty
  property p_p3_set;
    $rose(third_prox_irq_flag_q)
      |-> $past(prox3_meas.done && third_prox_irq_enable);
  endproperty
  property p_host; 1 |=> host_irq_q == $past(cmd_on || p3_on); endproperty
  property p_wake_gap; wake_q |=> s_quiet; endproperty
  property p_light; light_meas_start_q |-> $past(wake_q); endproperty
  property p_prox; prox_meas_start_q |-> $past(wake_q); endproperty
  property p_stop; stopped && $past(stopped) |-> !wake_q; endproperty
  property p_cmd_clr;
    $fell(command_irq_flag_q) |-> $past(command_irq_clr);
  endproperty
  // sticky flag may only drop on its own clear pulse
  property p_p3_clr;
    $fell(third_prox_irq_flag_q) |-> $past(third_prox_irq_clr);
  endproperty
  a_cmd_set: assert property (p_cmd_set)
    else $error("stray command flag");
  a_p3_set: assert property (p_p3_set)
    else $error("stray third flag");
  a_host: assert property (p_host)
    else $error("host pin mismatch");
  a_wake_gap: assert property (p_wake_gap)
    else $error("wake too soon");
  a_light: assert property (p_light)
    else $error("light not on wake");
  a_prox: assert property (p_prox)
    else $error("prox not on wake");
  a_stop: assert property (p_stop)
    else $error("wake while stopped");
  a_cmd_clr: assert property (p_cmd_clr)
    else $error("flag lost");
  a_p3_clr: assert property (p_p3_clr)
    else $error("third flag lost");
endmodule : msi_checker

bind msi_sched msi_checker u_msi_checker (.mclk, .rst_n, .command_irq_enable,
  .third_prox_irq_enable, .reply_wr, .prox3_meas, .command_irq_clr,
  .third_prox_irq_clr, .command_irq_flag_q, .third_prox_irq_flag_q,
  .host_irq_q, .osc_run_q, .wake_q, .light_meas_start_q,
  .prox_meas_start_q);

// ===== tb/msi_host.sv
// host model issuing byte register accesses
`timescale 1ns/1ps
module msi_host (
  input logic mclk,
  output msi_pkg::msi_req_t reg_req,
  input logic [7:0] reg_rdata_q
);
  initial reg_req = '0;
  // released lines show inverted values so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{1'b1, a, d};
    @(posedge mclk);
    reg_req <= '{1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{1'b0, a, 8'h00};
    @(posedge mclk);
    @(negedge mclk);
    d = reg_rdata_q;
  endtask : rd
endmodule : msi_host

// ===== tb/tb_msi_sched.sv
// self-checking bench for the schedule block
`timescale 1ns/1ps
module tb_msi_sched;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic command_irq_enable = 1'b1;
  logic third_prox_irq_enable = 1'b1;
  logic continuous_run_mode = 1'b0;
  logic reply_wr = 1'b0;
  logic [7:0] reply_data = 8'h00;
  msi_pkg::msi_meas_t prox3_meas = '0;
  logic [15:0] third_prox_threshold = 16'h0064;
  logic command_irq_clr = 1'b0;
  logic third_prox_irq_clr = 1'b0;
  msi_pkg::msi_req_t reg_req;
  logic [7:0] reg_rdata_q, d;
  logic command_irq_flag_q, third_prox_irq_flag_q, host_irq_q, unlocked_q;
  logic osc_run_q, wake_q, light_meas_start_q, prox_meas_start_q;
  int failures = 0, n_checks = 0, cyc = 0, nw = 0, nl = 0, np = 0;
  int t0, w0, l0, p0;
  always #10 mclk = ~mclk;
  msi_host u_msi_host (.mclk, .reg_req, .reg_rdata_q);
  msi_sched u_msi_sched (.mclk, .rst_n, .reg_req, .reg_rdata_q,
    .command_irq_enable, .third_prox_irq_enable, .continuous_run_mode,
    .reply_wr, .reply_data, .prox3_meas, .third_prox_threshold,
    .command_irq_clr, .third_prox_irq_clr, .command_irq_flag_q,
    .third_prox_irq_flag_q, .host_irq_q, .unlocked_q, .osc_run_q, .wake_q,
    .light_meas_start_q, .prox_meas_start_q);
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    nw <= nw + int'(wake_q);
    nl <= nl + int'(light_meas_start_q);
    np <= np + int'(prox_meas_start_q);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  always @(posedge mclk) if (cyc == 90000) begin
    failures++;
    end_sim();
  end
  // one reply write or third-channel result, then both flags cleared
  task automatic fire(input bit p3, input logic [15:0] v, input logic e);
    @(posedge mclk);
    if (p3) prox3_meas <= '{1'b1, v};
    else begin
      reply_wr <= 1'b1;
      reply_data <= v[7:0];
    end
    @(posedge mclk);
    reply_wr <= 1'b0;
    prox3_meas <= '{1'b0, ~v};
    @(negedge mclk);
    chk(16'(p3 ? third_prox_irq_flag_q : command_irq_flag_q), 16'(e));
    @(negedge mclk);
    chk(16'(host_irq_q), 16'(e));
    @(posedge mclk);
    command_irq_clr <= 1'b1;
    third_prox_irq_clr <= 1'b1;
    @(posedge mclk);
    command_irq_clr <= 1'b0;
    third_prox_irq_clr <= 1'b0;
  endtask : fire
  task automatic wake_wait;
    do @(negedge mclk); while (wake_q !== 1'b1);
  endtask : wake_wait
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 6; a < 12; a++) begin
      u_msi_host.rd(8'(a), d);
      chk(16'(d), 16'h0000);
    end
    chk(16'(unlocked_q), 16'h0000);
    u_msi_host.wr(8'h06, 8'hFF);
    u_msi_host.rd(8'h06, d);
    chk(16'(d), 16'h000F);
    u_msi_host.wr(8'h07, 8'h17);
    u_msi_host.rd(8'h07, d);
    chk(16'({d, unlocked_q}), {7'h00, 8'h17, 1'b1});
    u_msi_host.wr(8'h06, 8'h00);
    fire(1'b0, 16'h0001, 1'b1);
    fire(1'b1, 16'h0005, 1'b1);
    command_irq_enable <= 1'b0;
    fire(1'b0, 16'h0001, 1'b0);
    command_irq_enable <= 1'b1;
    u_msi_host.wr(8'h06, 8'h04);
    fire(1'b0, 16'h0000, 1'b0);
    fire(1'b0, 16'h0080, 1'b1);
    u_msi_host.wr(8'h06, 8'h08);
    fire(1'b0, 16'h0080, 1'b0);
    u_msi_host.wr(8'h06, 8'h03);
    fire(1'b1, 16'h0032, 1'b0);
    fire(1'b1, 16'h0096, 1'b1);
    // third-channel mode 10 has no meaning and must never set the flag
    u_msi_host.wr(8'h06, 8'h02);
    fire(1'b1, 16'h00C8, 1'b0);
    u_msi_host.wr(8'h06, 8'h01);
    fire(1'b1, 16'h00A0, 1'b0);
    fire(1'b1, 16'h0028, 1'b1);
    fire(1'b1, 16'h00C8, 1'b1);
    continuous_run_mode <= 1'b1;
    u_msi_host.wr(8'h09, 8'h08);
    u_msi_host.wr(8'h0A, 8'h00);
    u_msi_host.wr(8'h08, 8'h18);
    w0 = nw;
    l0 = nl;
    p0 = np;
    wake_wait();
    chk(16'(osc_run_q), 16'h0001);
    wake_wait();
    t0 = cyc;
    wake_wait();
    // 218.75 us is 10937.5 cycles, so either rounding is right
    chk(16'(cyc - t0 - 10937) >> 1, 16'h0000);
    repeat (3) @(negedge mclk);
    chk(16'(nw - w0), 16'h0003);
    chk(16'(nl - l0), 16'h0003);
    chk(16'(np - p0), 16'h0000);
    u_msi_host.wr(8'h09, 8'h00);
    u_msi_host.wr(8'h0A, 8'h08);
    l0 = nl;
    p0 = np;
    wake_wait();
    wake_wait();
    repeat (3) @(negedge mclk);
    chk(16'(nl - l0), 16'h0000);
    chk(16'(np - p0), 16'h0002);
    u_msi_host.wr(8'h08, 8'h00);
    repeat (3) @(negedge mclk);
    chk(16'(osc_run_q), 16'h0000);
    w0 = nw;
    repeat (12000) @(posedge mclk);
    chk(16'(nw - w0), 16'h0000);
    // restart, leave a flag pending, then reset in mid-run
    u_msi_host.wr(8'h08, 8'h84);
    repeat (3) @(negedge mclk);
    chk(16'(osc_run_q), 16'h0001);
    @(posedge mclk);
    reply_wr <= 1'b1;
    @(posedge mclk);
    reply_wr <= 1'b0;
    @(negedge mclk);
    chk(16'(command_irq_flag_q), 16'h0001);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(16'({command_irq_flag_q, host_irq_q}), 16'h0000);
    chk(16'({osc_run_q, unlocked_q}), 16'h0000);
    u_msi_host.rd(8'h08, d);
    chk(16'(d), 16'h0000);
    u_msi_host.rd(8'h07, d);
    chk(16'(d), 16'h0000);
    end_sim();
  end
endmodule : tb_msi_sched
